// File: common/csm_consts.vh
// Constants for the configurable signed multiplier.
// Assumes inclusion by bare name from design files.
`ifndef CSM_CONSTS_VH
`define CSM_CONSTS_VH
`define CSM_WIDE_W 18
`define CSM_NARROW_W 9
`define CSM_WIDE_P 36
`define CSM_NARROW_P 18
`define CSM_MODE_WIDE 1'h0
`define CSM_MODE_NARROW 1'h1
`define CSM_RST_OPND 18'h00000
`define CSM_RST_PROD 36'h000000000
`define CSM_RST_SIGN 1'h0
`define CSM_LSB_HI 18
`define CSM_PROD_HI_LSB 18
`endif

// File: verilog/csm_mult_core.v
// Combinational signed/unsigned multiplier core, 18x18 or two 9x9.
// Assumes operands and sign controls already chosen (registered or not).
`timescale 1ns/1ps
`default_nettype none
`include "csm_consts.vh"
module csm_mult_core (
    input wire i_mode,
    input wire i_sign_a,
    input wire i_sign_b,
    input wire [17:0] i_opnd_a,
    input wire [17:0] i_opnd_b,
    output wire [35:0] o_prod
);
    // ----------------------------------------
    // Sign-extend by one bit, multiply at full width
    // ----------------------------------------
    function [37:0] smul19;
        input [18:0] a;
        input [18:0] b;
        reg signed [37:0] p;
        begin
            p = $signed(a) * $signed(b);
            smul19 = p;
        end
    endfunction

    wire [18:0] wide_a;
    wire [18:0] wide_b;
    wire [18:0] lo_a;
    wire [18:0] lo_b;
    wire [18:0] hi_a;
    wire [18:0] hi_b;
    wire [37:0] wide_p;
    wire [37:0] lo_p;
    wire [37:0] hi_p;

    // Extra top bit makes unsigned operands positive
    assign wide_a = {i_sign_a & i_opnd_a[17], i_opnd_a};
    assign wide_b = {i_sign_b & i_opnd_b[17], i_opnd_b};
    // Both halves share the same sign controls
    assign lo_a = {{10{i_sign_a & i_opnd_a[8]}}, i_opnd_a[8:0]};
    assign lo_b = {{10{i_sign_b & i_opnd_b[8]}}, i_opnd_b[8:0]};
    assign hi_a = {{10{i_sign_a & i_opnd_a[17]}}, i_opnd_a[17:9]};
    assign hi_b = {{10{i_sign_b & i_opnd_b[17]}}, i_opnd_b[17:9]};

    assign wide_p = smul19(wide_a, wide_b);
    assign lo_p = smul19(lo_a, lo_b);
    assign hi_p = smul19(hi_a, hi_b);

    // Low half product in [17:0], high half product in [35:18]
    assign o_prod = (i_mode == `CSM_MODE_NARROW) ? {hi_p[17:0], lo_p[17:0]} : wide_p[35:0];
endmodule // csm_mult_core
`default_nettype wire

// File: verilog/csm_mult_top.v
// Configurable signed multiplier with optional input, sign and output stages.
// Assumes operands and controls synchronous to i_core_clk; config static-ish.
//
// Behaviour
// - Wide mode multiplies two 18-bit operands into the full product.
// - Narrow mode runs two independent 9x9 multiplications in parallel.
// - A sign control at 1 marks its operand signed, at 0 unsigned.
// - The product is signed when either operand is signed.
// - Sign controls may change at run time and apply to later operands.
// - The product is full precision with no truncation or rounding.
// - Sign controls may pass through one register stage with the operands.
// - Operand and product stages are each selectable, used or bypassed.
// - All stage registers share one clock, one enable and one clear.
`timescale 1ns/1ps
`default_nettype none
`include "csm_consts.vh"
module csm_mult_top (
    input wire i_core_clk,
    input wire i_rst_b,
    input wire i_clk_en,
    input wire i_aclr,
    input wire i_mode,
    input wire i_in_reg_en,
    input wire i_sign_reg_en,
    input wire i_out_reg_en,
    input wire i_sign_a,
    input wire i_sign_b,
    input wire [17:0] i_opnd_a,
    input wire [17:0] i_opnd_b,
    output reg [35:0] o_prod,
    output reg o_prod_signed
);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Small selectors shared by the stage muxes below
    // Result is signed when either operand is signed
    function res_signed;
        input sa;
        input sb;
        begin
            res_signed = sa | sb;
        end
    endfunction

    // Stage bypass pick for an operand word
    function [17:0] pick_word;
        input use_stage;
        input [17:0] staged;
        input [17:0] live;
        begin
            pick_word = use_stage ? staged : live;
        end
    endfunction

    // Stage bypass pick for one control bit
    function pick_bit;
        input use_stage;
        input staged;
        input live;
        begin
            pick_bit = use_stage ? staged : live;
        end
    endfunction

    // Stage bypass pick for the full product
    function [35:0] pick_prod;
        input use_stage;
        input [35:0] staged;
        input [35:0] live;
        begin
            pick_prod = use_stage ? staged : live;
        end
    endfunction

    // ----------------------------------------
    // Reset release
    // ----------------------------------------
    // Two flops so the stages leave reset on a clock edge, not mid-cycle
    reg rst_meta_q;
    reg rst_sync_q;
    always @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_meta_q <= 1'h0;
            rst_sync_q <= 1'h0;
        end else begin
            rst_meta_q <= 1'h1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // ----------------------------------------
    // Clear
    // ----------------------------------------
    // Either clear source empties every stage at once. The clear is a gated
    // level, so i_aclr must be glitch-free and released clear of a clock edge.
    wire clr_n;
    assign clr_n = rst_sync_q & ~i_aclr;

    // ----------------------------------------
    // Operand input stage
    // ----------------------------------------
    reg [17:0] opnd_a_q;
    reg [17:0] opnd_b_q;
    // One clock, one enable, one async clear for every stage
    always @(posedge i_core_clk or negedge clr_n) begin
        if (!clr_n) begin
            opnd_a_q <= `CSM_RST_OPND;
        end else if (i_clk_en) begin
            opnd_a_q <= i_opnd_a;
        end
    end

    always @(posedge i_core_clk or negedge clr_n) begin
        if (!clr_n) begin
            opnd_b_q <= `CSM_RST_OPND;
        end else if (i_clk_en) begin
            opnd_b_q <= i_opnd_b;
        end
    end

    // ----------------------------------------
    // Sign control stage
    // ----------------------------------------
    // Sits at the operand stage so a sign change lands with its operands.
    // Keep i_sign_reg_en equal to i_in_reg_en, or signs slip by one word.
    reg sign_a_q;
    reg sign_b_q;
    always @(posedge i_core_clk or negedge clr_n) begin
        if (!clr_n) begin
            sign_a_q <= `CSM_RST_SIGN;
        end else if (i_clk_en) begin
            sign_a_q <= i_sign_a;
        end
    end

    always @(posedge i_core_clk or negedge clr_n) begin
        if (!clr_n) begin
            sign_b_q <= `CSM_RST_SIGN;
        end else if (i_clk_en) begin
            sign_b_q <= i_sign_b;
        end
    end

    // ----------------------------------------
    // Stage bypass
    // ----------------------------------------
    // Chosen live, so flipping an enable mid-stream yields one mixed word
    wire [17:0] use_a;
    wire [17:0] use_b;
    wire use_sa;
    wire use_sb;
    wire use_signed;
    assign use_a = pick_word(i_in_reg_en, opnd_a_q, i_opnd_a);
    assign use_b = pick_word(i_in_reg_en, opnd_b_q, i_opnd_b);
    // New sign setting takes effect on the next operands seen
    assign use_sa = pick_bit(i_sign_reg_en, sign_a_q, i_sign_a);
    assign use_sb = pick_bit(i_sign_reg_en, sign_b_q, i_sign_b);
    assign use_signed = res_signed(use_sa, use_sb);

    // ----------------------------------------
    // Multiplier array
    // ----------------------------------------
    // Pure combinational; narrow mode packs the high pair above the low pair
    wire [35:0] core_prod;
    csm_mult_core u_core (
        .i_mode(i_mode),
        .i_sign_a(use_sa),
        .i_sign_b(use_sb),
        .i_opnd_a(use_a),
        .i_opnd_b(use_b),
        .o_prod(core_prod)
    );

    // ----------------------------------------
    // Product stage
    // ----------------------------------------
    // Optional pipeline stage between the array and the output flops
    reg [35:0] prod_q;
    reg psign_q;
    always @(posedge i_core_clk or negedge clr_n) begin
        if (!clr_n) begin
            prod_q <= `CSM_RST_PROD;
        end else if (i_clk_en) begin
            prod_q <= core_prod;
        end
    end

    // Sign of the staged result travels beside it
    always @(posedge i_core_clk or negedge clr_n) begin
        if (!clr_n) begin
            psign_q <= `CSM_RST_SIGN;
        end else if (i_clk_en) begin
            psign_q <= use_signed;
        end
    end

    // ----------------------------------------
    // Output capture
    // ----------------------------------------
    // Outputs must come from flops, so bypass mode still costs one capture
    // cycle; the output stage adds a second when enabled.
    // Product latency: 1 + input stage + output stage, in enabled edges.
    // Sign flag latency: 1 + sign stage + output stage, in enabled edges.
    always @(posedge i_core_clk or negedge clr_n) begin
        if (!clr_n) begin
            o_prod <= `CSM_RST_PROD;
        end else if (i_clk_en) begin
            o_prod <= pick_prod(i_out_reg_en, prod_q, core_prod);
        end
    end

    always @(posedge i_core_clk or negedge clr_n) begin
        if (!clr_n) begin
            o_prod_signed <= `CSM_RST_SIGN;
        end else if (i_clk_en) begin
            o_prod_signed <= pick_bit(i_out_reg_en, psign_q, use_signed);
        end
    end
endmodule // csm_mult_top
`default_nettype wire

// File: test/csm_user_model.sv
// User logic feeding operands and sign controls.
// Assumes the bench calls send at clock rate.
`timescale 1ns/1ps
`default_nettype none
module csm_user_model (
    input wire logic i_core_clk,
    output logic [17:0] o_a,
    output logic [17:0] o_b,
    output logic o_sa,
    output logic o_sb
);
    initial {o_a, o_b, o_sa, o_sb} = '0;
    // One sign pair serves both halves
    task send(input [17:0] a, input [17:0] b, input sa, input sb);
        @(posedge i_core_clk);
        {o_a, o_b, o_sa, o_sb} <= {a, b, sa, sb};
    endtask
endmodule // csm_user_model
`default_nettype wire

// File: test/csm_chk_asserts.sv
// Checker on the multiplier ports.
// Assumes stage enables held steady while a result is in flight.
`timescale 1ns/1ps
`default_nettype none
module csm_chk (
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic i_clk_en,
    input wire logic i_aclr,
    input wire logic i_mode,
    input wire logic i_in_reg_en,
    input wire logic i_sign_reg_en,
    input wire logic i_out_reg_en,
    input wire logic i_sign_a,
    input wire logic i_sign_b,
    input wire logic [17:0] i_opnd_a,
    input wire logic [17:0] i_opnd_b,
    input wire logic [35:0] o_prod,
    input wire logic o_prod_signed
);
    wire [37:0] ew = $signed({i_sign_a & i_opnd_a[17], i_opnd_a})
        * $signed({i_sign_b & i_opnd_b[17], i_opnd_b});
    wire [19:0] el = $signed({i_sign_a & i_opnd_a[8], i_opnd_a[8:0]})
        * $signed({i_sign_b & i_opnd_b[8], i_opnd_b[8:0]});
    wire [19:0] eh = $signed({i_sign_a & i_opnd_a[17], i_opnd_a[17:9]})
        * $signed({i_sign_b & i_opnd_b[17], i_opnd_b[17:9]});
    wire plain = i_clk_en & ~i_in_reg_en & ~i_out_reg_en & ~i_sign_reg_en;
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b || i_aclr);
    sequence staged;
        (i_clk_en & i_in_reg_en & i_sign_reg_en & i_out_reg_en & ~i_mode) [*3];
    endsequence
    wide_prod_a: assert property (plain & ~i_mode |=> o_prod == $past(ew[35:0]))
        else $error("wide product wrong");
    narrow_lo_a: assert property (plain & i_mode |=> o_prod[17:0] == $past(el[17:0]))
        else $error("low product wrong");
    narrow_hi_a: assert property (plain & i_mode |=> o_prod[35:18] == $past(eh[17:0]))
        else $error("high product wrong");
    result_sign_a: assert property (plain |=> o_prod_signed == $past(i_sign_a | i_sign_b))
        else $error("result sign wrong");
    stage_path_a: assert property (staged |=> o_prod == $past(ew[35:0], 3))
        else $error("staged product wrong");
    sign_stage_a: assert property (staged |=> o_prod_signed == $past(i_sign_a | i_sign_b, 3))
        else $error("staged sign wrong");
    enable_hold_a: assert property (!i_clk_en |=> $stable(o_prod))
        else $error("product moved while disabled");
    clear_zero_a: assert property (disable iff (!i_rst_b) i_aclr |-> o_prod == 36'h0)
        else $error("clear left product");
endmodule // csm_chk
bind csm_mult_top csm_chk u_chk (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
    .i_clk_en(i_clk_en), .i_aclr(i_aclr), .i_mode(i_mode), .i_in_reg_en(i_in_reg_en),
    .i_sign_reg_en(i_sign_reg_en), .i_out_reg_en(i_out_reg_en), .i_sign_a(i_sign_a),
    .i_sign_b(i_sign_b), .i_opnd_a(i_opnd_a), .i_opnd_b(i_opnd_b), .o_prod(o_prod),
    .o_prod_signed(o_prod_signed));
`default_nettype wire

// File: test/testbench.sv
// Self-checking bench for the multiplier.
// Assumes the user model drives operands and signs.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk = 0, rst_b = 0, en = 1, aclr = 0, md = 0, ir = 0, sr = 0, orr = 0;
    logic [17:0] a, b;
    logic sa, sb, ps;
    logic [35:0] p;
    int bad_count = 0, cmp_count = 0;
    always #2.5 clk = ~clk;
    csm_user_model usr (.i_core_clk(clk), .o_a(a), .o_b(b), .o_sa(sa), .o_sb(sb));
    csm_mult_top DUT (.i_core_clk(clk), .i_rst_b(rst_b), .i_clk_en(en), .i_aclr(aclr),
        .i_mode(md), .i_in_reg_en(ir), .i_sign_reg_en(sr), .i_out_reg_en(orr),
        .i_sign_a(sa), .i_sign_b(sb), .i_opnd_a(a), .i_opnd_b(b), .o_prod(p),
        .o_prod_signed(ps));
    function automatic [35:0] mul(input [17:0] x, y, input s, t, m);
        mul = m ? {18'($signed({s & x[17], x[17:9]}) * $signed({t & y[17], y[17:9]})),
            18'($signed({s & x[8], x[8:0]}) * $signed({t & y[8], y[8:0]}))}
            : 36'($signed({s & x[17], x}) * $signed({t & y[17], y}));
    endfunction
    task chk(input [36:0] got, exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task go(input [17:0] x, y, input s, t, int lat);
        usr.send(x, y, s, t);
        repeat (lat) @(posedge clk);
        #1 chk({ps, p}, {s | t, mul(x, y, s, t, md)});
    endtask
    task close_out;
        $display("mismatches %0d comparisons %0d", bad_count, cmp_count);
        if (bad_count == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst_b <= 1;
        repeat (4) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            @(posedge clk) md <= i[2];
            go(18'h3FF85, 18'h20103, i[1], i[0], 1);
        end
        @(posedge clk) {ir, sr, orr, md} <= 4'hE;
        go(18'h3FFFF, 18'h3FFFF, 1, 0, 3);
        @(posedge clk) {ir, sr, orr, md} <= 4'hD;
        go(18'h2A1FF, 18'h1FE01, 0, 1, 2);
        @(posedge clk) {ir, sr, orr, md} <= 4'h3;
        go(18'h1FF00, 18'h3FE80, 1, 1, 2);
        @(posedge clk) en <= 0;
        usr.send(18'h00005, 18'h00007, 0, 0);
        repeat (4) @(posedge clk);
        #1 chk({ps, p}, {1'b1, mul(18'h1FF00, 18'h3FE80, 1, 1, 1)});
        @(posedge clk) aclr <= 1;
        #1 chk({ps, p}, 37'h0);
        repeat (2) @(posedge clk);
        close_out;
    end
    initial begin
        #5000;
        bad_count++;
        close_out;
    end
endmodule // testbench
`default_nettype wire
